// ==== hw/pbs_pkg.sv ====
// shared constants and types of the pipelined burst sram control block
package pbs_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int PAR_W = 2;
   localparam int LANES = 2;
   localparam int WORD_W = 18;
   localparam int APB_AW = 12;
   // apb register byte addresses
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   // field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int ST_DRIVE_BIT = 0;
   localparam int ST_READ_BIT = 1;
   localparam int ST_WRITE_BIT = 2;
   localparam int ST_COMMIT_BIT = 3;
   localparam int ST_BEAT_LSB = 4;
   // reset values and burst counter step
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam logic [1:0] BEAT_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h3;
   localparam logic [1:0] BEAT_STEP = 2'h1;
   // kind of the access a burst continues
   typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} pbs_access_type;
endpackage : pbs_pkg

// ==== hw/pbs_sram_control.sv ====
// cycle-level control of a pipelined burst sram with apb control and status
`timescale 1ns/1ns
module pbs_sram_control (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_clock_qualifier_n,
   input wire logic i_chip_enable1_n,
   input wire logic i_chip_enable2,
   input wire logic i_chip_enable3_n,
   input wire logic i_burst_step_or_load,
   input wire logic i_write_n,
   input wire logic [pbs_pkg::LANES-1:0] i_byte_lane_mask_n,
   input wire logic i_burst_order,
   input wire logic i_output_enable_n,
   input wire logic [pbs_pkg::ADDR_W-1:0] i_address,
   input wire logic [pbs_pkg::DATA_W-1:0] i_dq,
   input wire logic [pbs_pkg::PAR_W-1:0] i_parity_lines,
   output logic [pbs_pkg::DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   output logic [pbs_pkg::PAR_W-1:0] o_parity_lines,
   output logic o_parity_lines_oe,
   output logic [pbs_pkg::ADDR_W-1:0] o_mem_raddr,
   output logic o_mem_read,
   input wire logic [pbs_pkg::WORD_W-1:0] i_mem_rdata,
   output logic [pbs_pkg::ADDR_W-1:0] o_mem_waddr,
   output logic [pbs_pkg::WORD_W-1:0] o_mem_wdata,
   output logic [pbs_pkg::LANES-1:0] o_mem_lane_write,
   output logic o_mem_write,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [pbs_pkg::APB_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   import pbs_pkg::*;

   logic ctrl_enable;
   logic s1_read;
   logic s1_write;
   logic [ADDR_W-1:0] s1_addr;
   logic [LANES-1:0] s1_mask_n;
   logic [1:0] burst_base;
   logic [1:0] beat_cnt;
   pbs_access_type last_acc;
   logic s2_write;
   logic [ADDR_W-1:0] s2_addr;
   logic [LANES-1:0] s2_mask_n;
   logic o_drive;
   logic burst_ok;
   logic burst_is_write;

   // edge qualification and cycle decode
   wire go = ~i_clock_qualifier_n;
   wire sel = ~i_chip_enable1_n & i_chip_enable2 & ~i_chip_enable3_n & ctrl_enable;
   wire load = go & ~i_burst_step_or_load;
   wire advance = go & i_burst_step_or_load;
   wire begin_read = load & sel & i_write_n;
   wire begin_write = load & sel & ~i_write_n;
   wire step = advance & burst_ok;
   wire [1:0] next_beat = 2'(beat_cnt + BEAT_STEP);
   wire [1:0] step_linear = 2'(burst_base + next_beat);
   wire [1:0] step_inter = burst_base ^ next_beat;
   wire [1:0] step_low = i_burst_order ? step_inter : step_linear;

   // what an advance continues
   always_comb begin
      burst_ok = 1'b0;
      burst_is_write = 1'b0;
      case (last_acc)
         ACC_READ: begin
            burst_ok = 1'b1;
         end
         ACC_WRITE: begin
            burst_ok = 1'b1;
            burst_is_write = 1'b1;
         end
         ACC_IDLE: burst_ok = 1'b0;
         default: burst_ok = 1'b0;
      endcase
   end

   // address stage: load, burst step or deselect
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_read <= 1'b0;
         s1_write <= 1'b0;
         s1_addr <= '0;
         s1_mask_n <= MASK_RESET;
         burst_base <= BEAT_RESET;
         beat_cnt <= BEAT_RESET;
         last_acc <= ACC_IDLE;
      end else if (load) begin
         s1_read <= begin_read;
         s1_write <= begin_write;
         s1_addr <= i_address;
         s1_mask_n <= i_byte_lane_mask_n;
         burst_base <= i_address[1:0];
         beat_cnt <= BEAT_RESET;
         last_acc <= begin_write ? ACC_WRITE : (begin_read ? ACC_READ : ACC_IDLE);
      end else if (step) begin
         s1_read <= ~burst_is_write;
         s1_write <= burst_is_write;
         s1_addr <= {s1_addr[ADDR_W-1:2], step_low};
         s1_mask_n <= i_byte_lane_mask_n;
         beat_cnt <= next_beat;
      end else if (advance) begin
         s1_read <= 1'b0;
         s1_write <= 1'b0;
      end
   end

   // data stage: drive read data or float for write data
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_drive <= 1'b0;
         o_dq <= '0;
         o_parity_lines <= '0;
         s2_write <= 1'b0;
         s2_addr <= '0;
         s2_mask_n <= MASK_RESET;
      end else if (go) begin
         o_drive <= s1_read;
         s2_write <= s1_write;
         s2_addr <= s1_addr;
         s2_mask_n <= s1_mask_n;
         if (s1_read) begin
            o_dq <= i_mem_rdata[DATA_W-1:0];
            o_parity_lines <= i_mem_rdata[WORD_W-1:DATA_W];
         end
      end
   end

   // commit stage: write data taken two valid clocks after each write beat, load or burst step
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mem_write <= 1'b0;
         o_mem_waddr <= '0;
         o_mem_wdata <= '0;
         o_mem_lane_write <= '0;
      end else begin
         o_mem_write <= go & s2_write;
         if (go && s2_write) begin
            o_mem_waddr <= s2_addr;
            o_mem_wdata <= {i_parity_lines, i_dq};
            o_mem_lane_write <= ~s2_mask_n;
         end
      end
   end

   // memory read port follows the address stage
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mem_read <= 1'b0;
      end else if (go) begin
         o_mem_read <= load ? begin_read : (step & ~burst_is_write);
      end
   end
   assign o_mem_raddr = s1_addr;

   // pin drivers: pipelined cycle and asynchronous output enable together
   assign o_dq_oe = o_drive & ~i_output_enable_n;
   assign o_parity_lines_oe = o_drive & ~i_output_enable_n;

   // apb slave, one wait state, write commits at the completing edge
   wire apb_access = i_psel & i_penable;
   wire hit_ctrl = i_paddr == CTRL_OFFSET;
   wire hit_status = i_paddr == STATUS_OFFSET;
   wire apb_bad = ~(hit_ctrl | hit_status) | (i_pwrite & hit_status);
   wire [31:0] status_word = {26'h0, beat_cnt, o_mem_write, s1_write, s1_read, o_drive};
   wire [31:0] read_word = hit_ctrl ? {31'h0, ctrl_enable} : (hit_status ? status_word : 32'h0);

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0;
         ctrl_enable <= CTRL_ENABLE_RESET;
      end else begin
         o_pready <= apb_access & ~o_pready;
         o_pslverr <= apb_access & ~o_pready & apb_bad;
         if (apb_access && !o_pready && !i_pwrite) begin
            o_prdata <= read_word;
         end
         if (apb_access && o_pready && i_pwrite && hit_ctrl) begin
            ctrl_enable <= i_pwdata[CTRL_ENABLE_BIT];
         end
      end
   end

   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   a_suspend_holds: assert property (!go |=> $stable(s1_addr) && $stable(o_drive) && $stable(beat_cnt))
      else $error("suspended edge changed state");
   a_deselect_floats: assert property ((load && !sel) ##1 go |=> !o_drive)
      else $error("deselect did not float drivers");
   a_read_drives: assert property (begin_read ##1 go |=> o_drive)
      else $error("read data not driven after latch");
   a_write_floats: assert property (begin_write ##1 go |=> !o_drive ##0 !o_dq_oe)
      else $error("drivers active in write data cycle");
   a_write_commit: assert property (begin_write ##1 go ##1 go |=> o_mem_write
      && o_mem_lane_write == ~$past(i_byte_lane_mask_n, 3))
      else $error("write not committed two valid clocks later");
   a_beat_count: assert property (step |=> beat_cnt == 2'($past(beat_cnt) + BEAT_STEP))
      else $error("burst counter did not step");
   a_beat_address: assert property (step && !i_burst_order |=> s1_addr[1:0] == 2'(burst_base + beat_cnt))
      else $error("linear burst address wrong");
   a_inter_address: assert property (step && i_burst_order |=> s1_addr[1:0] == (burst_base ^ beat_cnt))
      else $error("interleaved burst address wrong");
   a_burst_type: assert property (step |=> (s1_write == $past(burst_is_write)) && (s1_read != s1_write))
      else $error("burst changed access type");
   a_reset_float: assert property ($rose(i_reset_n) |-> !o_drive && !o_dq_oe && !s1_read && !s1_write)
      else $error("not deselected after power-up");
   a_oe_gate: assert property (i_output_enable_n |-> !o_dq_oe && !o_parity_lines_oe)
      else $error("drivers on with output enable high");
endmodule : pbs_sram_control

// ==== tb/pbs_bus_partner.sv ====
// controller model: write data two recognized edges after each write beat
`timescale 1ns/1ns
module pbs_bus_partner (
   input wire logic i_clock,
   input wire logic i_clock_qualifier_n,
   input wire logic i_burst_step_or_load,
   input wire logic i_write,
   input wire logic [17:0] i_wdata,
   output logic [17:0] o_bus
);
   logic burst_write = 1'b0;
   logic [1:0] valid = 2'h0;
   logic [17:0] data0 = 18'h0, data1 = 18'h0, last = 18'h0;
   // write beat pipeline, frozen on ignored edges
   always @(posedge i_clock) begin
      if (!i_clock_qualifier_n) begin
         if (!i_burst_step_or_load) burst_write <= i_write;
         valid <= {valid[0], i_burst_step_or_load ? burst_write : i_write};
         {data1, data0} <= {data0, i_wdata};
         if (valid[1]) last <= data1;
      end
   end
   // released lines show the inverse of the last value
   assign o_bus = valid[1] ? data1 : ~last;
endmodule : pbs_bus_partner

// ==== tb/pbs_sram_control_bench.sv ====
// self-checking bench of the pipelined burst sram control block
`timescale 1ns/1ns
module pbs_sram_control_bench;
   import pbs_pkg::*;
   localparam logic [3:0] NOP = 4'h1, RD = 4'h3, WR = 4'h2, ADV = 4'h4, SUS = 4'hD;
   logic i_clock = 0, i_reset_n = 0, i_clock_qualifier_n = 0, i_chip_enable2 = 0, i_burst_step_or_load = 0;
   logic i_write_n = 1, i_burst_order = 0, i_output_enable_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic o_dq_oe, o_parity_lines_oe, o_mem_read, o_mem_write, o_pready, o_pslverr, err;
   logic [1:0] i_byte_lane_mask_n = 2'h3, o_parity_lines, o_mem_lane_write;
   logic [15:0] o_dq;
   logic [17:0] i_address = 0, wdata = 0, bus, part, prev, i_mem_rdata, o_mem_raddr, o_mem_waddr, o_mem_wdata;
   logic [17:0] mem [16];
   logic [11:0] i_paddr = 0;
   logic [31:0] i_pwdata = 0, o_prdata, rd;
   int err_total = 0, compares = 0;
   typedef struct {logic [1:0] mask; logic [17:0] data, result;} pbs_row_type;
   pbs_row_type rows [4] = '{'{2'h0, 18'h2A5A5, 18'h2A5A5}, '{2'h2, 18'h1C3C3, 18'h3A5C3},
      '{2'h1, 18'h0FF00, 18'h1FFC3}, '{2'h3, 18'h00000, 18'h1FFC3}};
   wire [3:0] wa = o_mem_waddr[3:0];
   pbs_sram_control i_dut (.i_clock, .i_reset_n, .i_clock_qualifier_n, .i_chip_enable1_n(1'b0), .i_chip_enable2,
      .i_chip_enable3_n(1'b0), .i_burst_step_or_load, .i_write_n, .i_byte_lane_mask_n, .i_burst_order,
      .i_output_enable_n, .i_address, .i_dq(bus[15:0]), .i_parity_lines(bus[17:16]), .o_dq, .o_dq_oe,
      .o_parity_lines, .o_parity_lines_oe, .o_mem_raddr, .o_mem_read, .i_mem_rdata, .o_mem_waddr, .o_mem_wdata,
      .o_mem_lane_write, .o_mem_write, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr);
   pbs_bus_partner i_partner (.i_clock, .i_clock_qualifier_n, .i_burst_step_or_load,
      .i_write(i_chip_enable2 && !i_write_n), .i_wdata(wdata), .o_bus(part));
   // shared data lines and backing array with per-lane writes
   assign bus = o_dq_oe ? {o_parity_lines, o_dq} : part;
   assign i_mem_rdata = mem[o_mem_raddr[3:0]];
   always @(posedge i_clock) begin
      if (o_mem_write === 1'b1 && o_mem_lane_write[0]) {mem[wa][16], mem[wa][7:0]} <= {o_mem_wdata[16], o_mem_wdata[7:0]};
      if (o_mem_write === 1'b1 && o_mem_lane_write[1]) {mem[wa][17], mem[wa][15:8]} <= {o_mem_wdata[17], o_mem_wdata[15:8]};
   end
   initial forever #20 i_clock = ~i_clock;
   // one bus command: {qualifier_n, step, enable2, write_n}
   task automatic op(input logic [3:0] c, input logic [1:0] m = 2'h3, input logic [17:0] a = 18'h0, d = 18'h0);
      @(posedge i_clock);
      {i_clock_qualifier_n, i_burst_step_or_load, i_chip_enable2, i_write_n, i_byte_lane_mask_n, i_address, wdata}
         <= {c, m, a, d};
   endtask : op
   // apb transfer, waits for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clock);
      {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
      @(posedge i_clock);
      i_penable <= 1'b1;
      for (n = 0; n < 50 && o_pready !== 1'b1; n++) @(posedge i_clock);
      rd = o_prdata;
      err = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
   endtask : apb
   task automatic chk(input string s, input logic [17:0] e, g);
      compares++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", s, e, g);
         err_total++;
      end
   endtask : chk
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // watchdog
   initial begin
      repeat (3000) @(posedge i_clock);
      err_total++;
      end_sim;
   end
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 18'h20000 | 18'(i);
      prev = 18'h20000;
      repeat (6) @(negedge i_clock);
      chk("oe_reset", 18'h0, o_dq_oe);
      @(posedge i_clock);
      i_reset_n <= 1'b1;
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk("ctrl", 18'h1, rd[17:0]);
      apb(1'b0, 12'h008, 32'h0);
      chk("slverr", 18'h1, err);
      // byte lane writes, each read back in the next row
      for (int r = 0; r < 5; r++) begin
         op(RD);
         op(r < 4 ? WR : NOP, rows[r % 4].mask, 18'h0, rows[r % 4].data);
         op(NOP);
         @(negedge i_clock);
         chk("word", prev, {o_parity_lines, o_dq});
         op(NOP);
         @(negedge i_clock);
         chk("oe_write", 18'h0, o_dq_oe);
         op(NOP);
         prev = rows[r % 4].result;
      end
      // four-beat bursts in both orders, enables and write_n ignored
      for (int md = 0; md < 2; md++) begin
         i_burst_order <= md[0];
         op(RD, 2'h3, 18'h5);
         for (int n = 0; n < 4; n++) begin
            op(n < 3 ? ADV : NOP);
            @(negedge i_clock);
            chk("beat", 18'(md ? 1 ^ n : (1 + n) % 4), 18'(o_mem_raddr[1:0]));
            chk("oe_beat", 18'(n > 0), o_dq_oe);
            chk("mem_read", 18'h1, o_mem_read);
         end
         op(NOP);
         op(NOP);
         @(negedge i_clock);
         chk("oe_desel", 18'h0, o_dq_oe);
      end
      // suspended edges change nothing
      op(RD, 2'h3, 18'h8);
      op(SUS);
      op(SUS);
      @(negedge i_clock);
      chk("sus_addr", 18'h8, o_mem_raddr);
      chk("sus_oe", 18'h0, o_dq_oe);
      op(ADV);
      op(NOP);
      @(negedge i_clock);
      chk("resume", 18'h9, o_mem_raddr);
      chk("oe_on", 18'h1, o_dq_oe);
      i_output_enable_n <= 1'b1;
      #1 chk("oe_async", 18'h0, o_dq_oe);
      i_output_enable_n <= 1'b0;
      // disabled block acts deselected
      apb(1'b1, CTRL_OFFSET, 32'h0);
      op(RD);
      op(NOP);
      op(NOP);
      @(negedge i_clock);
      chk("oe_off", 18'h0, o_dq_oe);
      end_sim;
   end
endmodule : pbs_sram_control_bench
